// File: logic/la_trig_eval.sv

`include "la_trig_params.svh"

module la_trig_eval
  import la_trig_pkg::*;
#(
  parameter int NUM_LEAF = 2,
  parameter int LEAF_SZ  = 4,
  parameter int BUS_W    = 8
) (
  input  wire logic                         CLK_I,
  input  wire logic                         RST_B_I,
  input  wire logic [7:0]                   ADDR_I,
  input  wire logic [31:0]                  WDATA_I,
  input  wire logic                         WR_I,
  input  wire logic                         RD_I,
  output logic      [31:0]                  RDATA_O,
  input  wire logic [NUM_LEAF*LEAF_SZ-1:0]  SIG_I,
  input  wire logic [BUS_W-1:0]             BUS_I,
  output logic                              TRIG_O,
  output logic                              TRIGGERED_O,
  output logic                              SAMPLE_EN_O,
  output logic                              IRQ_O
);

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int N_SIG = NUM_LEAF * LEAF_SZ;
  localparam int CW    = `COND_FIELD_W * N_SIG;
  localparam int GW    = `GRP_ROOT_LSB + 3;
  localparam int RW    = NUM_LEAF + 2;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    state_t            st;
    ctrl_t             ctrl;
    logic [CW-1:0]     cond;
    logic [GW-1:0]     grp;
    logic [BUS_W-1:0]  pat;
    logic [BUS_W-1:0]  care;
    logic [BUS_W-1:0]  cmp_a;
    logic [BUS_W-1:0]  cmp_b;
    logic [N_SIG-1:0]  prev;
    logic              prev_ok;
    logic              irq_stat;
    logic              irq_mask;
    logic              irq;
    logic              trig;
    logic [31:0]       rdata;
  } st_t;

  st_t r;
  st_t next_r;

  // ----------------------------------------
  // Reduction of one group
  // ----------------------------------------
  // Disabled members are neutral: one for AND, zero for OR and XOR.
  function automatic logic reduce(input red_t op, input logic [31:0] v, input logic [31:0] en);
    logic a;
    logic o;
    logic x;
    a = &(v | ~en);
    o = |(v & en);
    x = ^(v & en);
    unique case (op)
      RED_AND:   reduce = a;
      RED_OR:    reduce = o;
      RED_NAND:  reduce = ~a;
      RED_NOR:   reduce = ~o;
      RED_XOR:   reduce = x;
      RED_XNOR:  reduce = ~x;
      RED_TRUE:  reduce = 1'b1;
      RED_FALSE: reduce = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Per-signal match
  // ----------------------------------------
  logic [N_SIG-1:0]    sig_hit;
  logic [N_SIG-1:0]    sig_en;
  logic [NUM_LEAF-1:0] leaf_val;

  for (genvar i = 0; i < N_SIG; i++) begin : g_sig
    cond_t c;
    logic  rise;
    logic  fall;
    assign c    = cond_t'(r.cond[`COND_FIELD_W*i +: `COND_FIELD_W]);
    assign rise = r.prev_ok & ~r.prev[i] & SIG_I[i];
    assign fall = r.prev_ok & r.prev[i] & ~SIG_I[i];
    assign sig_en[i]  = (c != COND_DC) && (c <= COND_EITHER);
    assign sig_hit[i] = (c == COND_LOW)    ? ~SIG_I[i] :
                        (c == COND_HIGH)   ? SIG_I[i]  :
                        (c == COND_FALL)   ? fall      :
                        (c == COND_RISE)   ? rise      :
                        (c == COND_EITHER) ? (rise | fall) : 1'b0;
  end

  // Fixed parent-child wiring; only the op fields move behaviour
  for (genvar g = 0; g < NUM_LEAF; g++) begin : g_leaf
    assign leaf_val[g] = reduce(red_t'(r.grp[3*g +: 3]),
                                32'(sig_hit[g*LEAF_SZ +: LEAF_SZ]),
                                32'(sig_en[g*LEAF_SZ +: LEAF_SZ]));
  end

  // ----------------------------------------
  // Bus pattern and comparison
  // ----------------------------------------
  logic bus_en;
  logic bus_hit;
  logic lo_ok;
  logic hi_ok;
  logic cmp_hit;

  assign bus_en  = |r.care;
  assign bus_hit = ~|((BUS_I ^ r.pat) & r.care);

  // Unsigned compare; values are taken as loaded, no wider than the bus
  assign lo_ok = r.ctrl.lo_incl ? (BUS_I >= r.cmp_a) : (BUS_I > r.cmp_a);
  assign hi_ok = r.ctrl.hi_incl ? (BUS_I <= r.cmp_b) : (BUS_I < r.cmp_b);

  always_comb begin
    cmp_hit = 1'b0;
    if (r.ctrl.interval) begin
      cmp_hit = lo_ok & hi_ok;
    end else begin
      unique case (r.ctrl.op)
        CMP_GT:  cmp_hit = BUS_I > r.cmp_a;
        CMP_GE:  cmp_hit = BUS_I >= r.cmp_a;
        CMP_EQ:  cmp_hit = BUS_I == r.cmp_a;
        CMP_LE:  cmp_hit = BUS_I <= r.cmp_a;
        CMP_LT:  cmp_hit = BUS_I < r.cmp_a;
        default: cmp_hit = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Combination
  // ----------------------------------------
  logic [RW-1:0] root_v;
  logic [RW-1:0] root_en;
  logic          root_hit;
  logic          and_hit;
  logic          fire;

  // Compare mode adds the compare term and keeps every OR term
  assign root_v   = {cmp_hit, bus_hit, leaf_val};
  assign root_en  = {r.ctrl.mode == MODE_COMPARE, bus_en, {NUM_LEAF{1'b1}}};
  assign root_hit = reduce(red_t'(r.grp[`GRP_ROOT_LSB +: 3]),
                           32'(root_v), 32'(root_en));

  // In AND mode, nothing enabled means an immediate trigger, as in free-run capture
  assign and_hit = (&(sig_hit | ~sig_en)) & (bus_hit | ~bus_en);
  assign fire    = (r.ctrl.mode == MODE_AND) ? and_hit : root_hit;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic wr_ctrl;
  logic arm_req;
  logic abort_req;
  logic trig_ev;

  assign wr_ctrl   = WR_I && (ADDR_I == `OFF_CTRL);
  assign arm_req   = wr_ctrl && WDATA_I[`CTRL_ARM_BIT];
  assign abort_req = wr_ctrl && WDATA_I[`CTRL_ABORT_BIT];

  // ----------------------------------------
  // Capture control
  // ----------------------------------------
  state_t next_st;

  always_comb begin
    next_st = r.st;
    trig_ev = 1'b0;
    unique case (r.st)
      ST_IDLE: begin
        if (arm_req) begin
          next_st = ST_RUN;
        end
      end
      ST_RUN: begin
        // Abort wins over a fire in the same cycle
        if (abort_req) begin
          next_st = ST_IDLE;
        end else if (fire) begin
          next_st = ST_DONE;
          trig_ev = 1'b1;
        end
      end
      ST_DONE: begin
        if (arm_req) begin
          next_st = ST_RUN;
        end else if (abort_req) begin
          next_st = ST_IDLE;
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Decoded from the address alone; only a strobed read reaches the port
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (ADDR_I)
      `OFF_CTRL:     rd_word = 32'(r.ctrl);
      `OFF_STAT: begin
        rd_word[`STAT_RUN_BIT]  = r.st == ST_RUN;
        rd_word[`STAT_DONE_BIT] = r.st == ST_DONE;
        rd_word[`STAT_HIT_BIT]  = fire;
      end
      `OFF_IRQ_STAT: rd_word[`IRQ_TRIG_BIT] = r.irq_stat;
      `OFF_IRQ_MASK: rd_word[`IRQ_TRIG_BIT] = r.irq_mask;
      `OFF_COND:     rd_word = 32'(r.cond);
      `OFF_GROUP:    rd_word = 32'(r.grp);
      `OFF_PAT:      rd_word = 32'(r.pat);
      `OFF_CARE:     rd_word = 32'(r.care);
      `OFF_CMP_A:    rd_word = 32'(r.cmp_a);
      `OFF_CMP_B:    rd_word = 32'(r.cmp_b);
      default:       rd_word = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // Reset image
  // ----------------------------------------
  // Kept apart so the register process stays a single plain copy
  st_t rst_val;

  always_comb begin
    rst_val          = '0;
    rst_val.st       = ST_IDLE;
    rst_val.ctrl     = ctrl_t'(`CTRL_RST);
    rst_val.cond     = CW'(`COND_RST);
    rst_val.grp      = GW'(`GROUP_RST);
    rst_val.pat      = BUS_W'(`PAT_RST);
    rst_val.care     = BUS_W'(`CARE_RST);
    rst_val.cmp_a    = BUS_W'(`CMP_RST);
    rst_val.cmp_b    = BUS_W'(`CMP_RST);
    rst_val.prev     = '0;
    rst_val.prev_ok  = 1'b0;
    rst_val.irq_stat = 1'b0;
    rst_val.irq_mask = `MASK_RST;
    rst_val.irq      = 1'b0;
    rst_val.trig     = 1'b0;
    rst_val.rdata    = 32'h0000_0000;
  end

  // ----------------------------------------
  // State copy
  // ----------------------------------------
  always_comb begin
    next_r         = r;
    next_r.st      = next_st;
    next_r.trig    = trig_ev;
    next_r.rdata   = 32'h0000_0000;
    next_r.prev    = SIG_I;
    next_r.prev_ok = 1'b1;

    if (WR_I) begin
      unique case (ADDR_I)
        `OFF_CTRL: begin
          next_r.ctrl       = ctrl_t'(WDATA_I);
          next_r.ctrl.arm   = 1'b0;
          next_r.ctrl.abort = 1'b0;
          next_r.ctrl.rsvd  = '0;
        end
        `OFF_IRQ_STAT: begin
          if (WDATA_I[`IRQ_TRIG_BIT]) begin
            next_r.irq_stat = 1'b0;
          end
        end
        `OFF_IRQ_MASK: next_r.irq_mask = WDATA_I[`IRQ_TRIG_BIT];
        `OFF_COND:     next_r.cond     = WDATA_I[CW-1:0];
        `OFF_GROUP:    next_r.grp      = WDATA_I[GW-1:0];
        `OFF_PAT:      next_r.pat      = WDATA_I[BUS_W-1:0];
        `OFF_CARE:     next_r.care     = WDATA_I[BUS_W-1:0];
        `OFF_CMP_A:    next_r.cmp_a    = WDATA_I[BUS_W-1:0];
        `OFF_CMP_B:    next_r.cmp_b    = WDATA_I[BUS_W-1:0];
        default: ;
      endcase
    end

    // Set after clear, so an event in the clearing cycle survives
    if (trig_ev) begin
      next_r.irq_stat = 1'b1;
    end
    next_r.irq = next_r.irq_stat & next_r.irq_mask;

    if (RD_I) begin
      next_r.rdata = rd_word;
    end

    // Synchronous reset folded in here to keep one register process
    if (!RST_B_I) begin
      next_r = rst_val;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CLK_I) begin
    r <= next_r;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign RDATA_O     = r.rdata;
  assign TRIG_O      = r.trig;
  assign TRIGGERED_O = r.st[2];
  assign SAMPLE_EN_O = r.st[1];
  assign IRQ_O       = r.irq;

endmodule

// File: logic/la_trig_params.svh
`ifndef LA_TRIG_PARAMS_SVH
`define LA_TRIG_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_CTRL      8'h00
`define OFF_STAT      8'h04
`define OFF_IRQ_STAT  8'h08
`define OFF_IRQ_MASK  8'h0C
`define OFF_COND      8'h10
`define OFF_GROUP     8'h14
`define OFF_PAT       8'h18
`define OFF_CARE      8'h1C
`define OFF_CMP_A     8'h20
`define OFF_CMP_B     8'h24

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define CTRL_ARM_BIT    0
`define CTRL_ABORT_BIT  9
`define STAT_RUN_BIT    0
`define STAT_DONE_BIT   1
`define STAT_HIT_BIT    2
`define IRQ_TRIG_BIT    0
`define GRP_ROOT_LSB    12
`define COND_FIELD_W    3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RST   32'h0000_0000
`define COND_RST   32'h0000_0000
`define GROUP_RST  32'h0000_1009
`define PAT_RST    32'h0000_0000
`define CARE_RST   32'h0000_0000
`define CMP_RST    32'h0000_0000
`define MASK_RST   1'h0

`endif

// File: logic/la_trig_pkg.sv
package la_trig_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } state_t;

  typedef enum logic [2:0] {
    COND_DC     = 3'h0,
    COND_LOW    = 3'h1,
    COND_HIGH   = 3'h2,
    COND_FALL   = 3'h3,
    COND_RISE   = 3'h4,
    COND_EITHER = 3'h5
  } cond_t;

  typedef enum logic [2:0] {
    RED_AND   = 3'h0,
    RED_OR    = 3'h1,
    RED_NAND  = 3'h2,
    RED_NOR   = 3'h3,
    RED_XOR   = 3'h4,
    RED_XNOR  = 3'h5,
    RED_TRUE  = 3'h6,
    RED_FALSE = 3'h7
  } red_t;

  typedef enum logic [1:0] {
    MODE_AND     = 2'h0,
    MODE_OR      = 2'h1,
    MODE_COMPARE = 2'h2
  } mode_t;

  typedef enum logic [2:0] {
    CMP_GT = 3'h0,
    CMP_GE = 3'h1,
    CMP_EQ = 3'h2,
    CMP_LE = 3'h3,
    CMP_LT = 3'h4
  } cmp_op_t;

  typedef struct packed {
    logic [21:0] rsvd;
    logic        abort;
    logic        hi_incl;
    logic        lo_incl;
    cmp_op_t     op;
    logic        interval;
    mode_t       mode;
    logic        arm;
  } ctrl_t;

endpackage

// File: tb/la_sig_source.sv
module la_sig_source (
  input  wire logic       clk_i,
  input  wire logic [7:0] sig_want_i,
  input  wire logic [7:0] bus_want_i,
  output logic      [7:0] sig_o = 8'h00,
  output logic      [7:0] bus_o = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // Registered like user logic, so taps move only after an edge
  always_ff @(posedge clk_i) begin
    sig_o <= sig_want_i;
    bus_o <= bus_want_i;
  end
endmodule

// File: tb/la_trig_props.sv
module la_trig_props #(
  parameter int NUM_LEAF = 2,
  parameter int LEAF_SZ  = 4,
  parameter int BUS_W    = 8
) (
  input wire logic                        CLK_I,
  input wire logic                        RST_B_I,
  input wire logic [7:0]                  ADDR_I,
  input wire logic [31:0]                 WDATA_I,
  input wire logic                        WR_I,
  input wire logic                        RD_I,
  input wire logic [31:0]                 RDATA_O,
  input wire logic [NUM_LEAF*LEAF_SZ-1:0] SIG_I,
  input wire logic [BUS_W-1:0]            BUS_I,
  input wire logic                        TRIG_O,
  input wire logic                        TRIGGERED_O,
  input wire logic                        SAMPLE_EN_O,
  input wire logic                        IRQ_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  // ----------------------------------------
  // Trigger link
  // ----------------------------------------
  property p_trig_pulse; TRIG_O |=> !TRIG_O; endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trig pulse too long");
  property p_trig_done; TRIG_O |-> TRIGGERED_O && !SAMPLE_EN_O; endproperty
  a_trig_done: assert property (p_trig_done) else $error("fire did not stop capture");
  property p_rose_done; $rose(TRIGGERED_O) |-> TRIG_O; endproperty
  a_rose_done: assert property (p_rose_done) else $error("done without pulse");
  property p_hold_done; TRIGGERED_O && !WR_I |=> TRIGGERED_O; endproperty
  a_hold_done: assert property (p_hold_done) else $error("done dropped");
  property p_fire_run; TRIG_O |-> $past(SAMPLE_EN_O); endproperty
  a_fire_run: assert property (p_fire_run) else $error("fire outside sampling");
  property p_excl; SAMPLE_EN_O |-> !TRIGGERED_O; endproperty
  a_excl: assert property (p_excl) else $error("sampling while done");
  property p_arm;
    $rose(SAMPLE_EN_O) |-> $past(WR_I) && $past(ADDR_I) == 8'h00 && $past(WDATA_I[0]);
  endproperty
  a_arm: assert property (p_arm) else $error("sampling without arm");
  property p_irq_src;
    $rose(IRQ_O) |-> TRIG_O || ($past(WR_I) && $past(ADDR_I) == 8'h0C);
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("irq without event or mask");
  // Host reads only answer in the cycle after the strobe
  property p_rd_quiet; !$past(RD_I) |-> RDATA_O == 32'h0; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data out of slot");
endmodule

// File: tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, trig, trgd, sen, irq, itv, lo, hi;
  logic [7:0] addr = 8'h00, sw = 8'h00, bw = 8'h00, sig, bus, a, b, v;
  logic [31:0] wdata = 32'h0, rdata, r;
  logic [2:0] op;
  int n_fail = 0, n_compared = 0, seed = 32'hEA53;
  initial forever #12.5 clk = ~clk;
  la_sig_source src (.clk_i(clk), .sig_want_i(sw), .bus_want_i(bw), .sig_o(sig), .bus_o(bus));
  la_trig_eval #(.NUM_LEAF(2), .LEAF_SZ(4), .BUS_W(8)) dut (.CLK_I(clk), .RST_B_I(rst_b),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SIG_I(sig),
    .BUS_I(bus), .TRIG_O(trig), .TRIGGERED_O(trgd), .SAMPLE_EN_O(sen), .IRQ_O(irq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    addr <= ad; wdata <= d; wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rd_reg(input logic [7:0] ad, input logic [31:0] exp);
    @(posedge clk);
    addr <= ad; rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 check(rdata, exp);
  endtask
  // Arm, let it settle, then abort so the next case starts idle
  task automatic arm_chk(input logic [31:0] ctrl, input logic exp);
    wr_reg(8'h00, ctrl | 32'h1);
    repeat (4) @(posedge clk);
    #1 check({30'h0, trgd, sen}, {30'h0, exp, ~exp});
    wr_reg(8'h00, ctrl | 32'h200);
  endtask
  function automatic logic exp_cmp(input logic [7:0] x);
    if (itv) return (x > a || (lo && x == a)) && (x < b || (hi && x == b));
    case (op)
      3'h0: return x > a;
      3'h1: return x >= a;
      3'h2: return x == a;
      3'h3: return x <= a;
      default: return x < a;
    endcase
  endfunction
  task automatic end_of_test;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1;
    rd_reg(8'h14, 32'h1009);
    rd_reg(8'h30, 32'h0);
    $display("reset values done");
    for (int c = 0; c < 6; c++) begin
      wr_reg(8'h10, c);
      arm_chk(32'h0, c < 2);
    end
    wr_reg(8'h10, 32'h2);
    wr_reg(8'h18, 32'h5);
    wr_reg(8'h1C, 32'hF);
    bw <= 8'h35; sw <= 8'h01;
    arm_chk(32'h0, 1'b1);
    bw <= 8'h34;
    arm_chk(32'h0, 1'b0);
    bw <= 8'h35; sw <= 8'h00;
    arm_chk(32'h0, 1'b0);
    $display("and mode done");
    wr_reg(8'h1C, 32'h0);
    wr_reg(8'h10, 32'h492492);
    sw <= 8'h0F;
    // Leaf 0 true, leaf 1 false: root truth table 8'h56
    for (int k = 0; k < 8; k++) begin
      wr_reg(8'h14, 32'h9 | (k << 12));
      arm_chk(32'h2, (8'h56 >> k) & 1);
    end
    wr_reg(8'h14, 32'h1009);
    $display("groups done");
    wr_reg(8'h10, 32'h20);
    sw <= 8'h00;
    wr_reg(8'h00, 32'h3);
    repeat (3) @(posedge clk);
    #1 check({31'h0, trgd}, 32'h0);
    @(posedge clk);
    sw <= 8'h02;
    repeat (4) @(posedge clk);
    #1 check({31'h0, trgd}, 32'h1);
    rd_reg(8'h04, 32'h2);
    rd_reg(8'h00, 32'h2);
    wr_reg(8'h0C, 32'h1);
    repeat (2) @(posedge clk);
    #1 check({31'h0, irq}, 32'h1);
    rd_reg(8'h08, 32'h1);
    wr_reg(8'h08, 32'h1);
    repeat (2) @(posedge clk);
    #1 check({31'h0, irq}, 32'h0);
    wr_reg(8'h00, 32'h200);
    wr_reg(8'h10, 32'h0);
    $display("edge and irq done");
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      op = r[2:0] % 5; itv = r[3]; lo = r[4]; hi = r[5];
      a = r[15:8]; b = r[23:16];
      v = (i % 4 == 0) ? a : (i % 4 == 1) ? b : r[31:24];
      wr_reg(8'h20, {24'h0, a});
      wr_reg(8'h24, {24'h0, b});
      bw <= v;
      arm_chk({23'h0, hi, lo, op, itv, 3'h4}, exp_cmp(v));
    end
    $display("compare done");
    end_of_test;
  end
endmodule
bind la_trig_eval la_trig_props #(.NUM_LEAF(NUM_LEAF), .LEAF_SZ(LEAF_SZ), .BUS_W(BUS_W)) u_props (
  .CLK_I(CLK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .SIG_I(SIG_I), .BUS_I(BUS_I), .TRIG_O(TRIG_O),
  .TRIGGERED_O(TRIGGERED_O), .SAMPLE_EN_O(SAMPLE_EN_O), .IRQ_O(IRQ_O));
